//--- verilog/irq_level_pkg.sv
// Shared constants for the interrupt priority level configuration block
package irq_level_pkg;

  // Sizes
  localparam int NSRC    = 21;
  localparam int SRC_W   = 5;
  localparam int LEVEL_W = 2;
  localparam int NLEVEL  = 3;
  localparam int REG_W   = 16;
  localparam int FIELD_W = 2;
  localparam int NCFG    = 4;
  localparam int APB_AW  = 8;
  localparam int APB_DW  = 32;
  localparam int IDX_W   = 6;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG_2  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CFG_3  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CFG_4  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CFG_5  = 6'h05;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_MASK   = 6'h21;

  // Field codes
  localparam logic [FIELD_W-1:0] FIELD_OFF  = 2'h0;
  localparam logic [FIELD_W-1:0] FIELD_LVL0 = 2'h1;
  localparam logic [FIELD_W-1:0] FIELD_LVL1 = 2'h2;
  localparam logic [FIELD_W-1:0] FIELD_LVL2 = 2'h3;

  localparam logic [LEVEL_W-1:0] LEVEL_0 = 2'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_1 = 2'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_2 = 2'h2;

  // Reset values
  localparam logic [REG_W-1:0]  CFG_RESET    = 16'h0000;
  localparam logic [NSRC-1:0]   STATUS_RESET = 21'h000000;
  localparam logic [NSRC-1:0]   MASK_RESET   = 21'h000000;
  localparam logic [APB_DW-1:0] RDATA_ZERO   = 32'h00000000;

  // Writable bits of cfg_2..cfg_5 (element 0 is cfg_2); all else reads zero
  localparam logic [NCFG-1:0][REG_W-1:0] CFG_WMASK = {
    16'hFC00, 16'hFC3F, 16'hFFFC, 16'h0FCF
  };

  // Source order: flash_error, pll_unlocked, low_voltage, ext_request_b,
  // ext_request_a, port_d, port_e, port_f, can_msgbuf, can_wakeup,
  // can_error, can_busoff, serial0_rx_full, serial1_tx_empty,
  // serial1_rx_full, port_a, port_b, port_c, decoder1_index,
  // decoder1_home_wdog, uart1_rx_full
  localparam int SRC_CFG [NSRC] = '{
    0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3
  };
  localparam int SRC_LSB [NSRC] = '{
    10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0, 14, 12, 10
  };

endpackage : irq_level_pkg

//--- verilog/irq_fwd_if.sv
// Carrier between the register block and the level arbiter
`timescale 1ns/1ps
interface irq_fwd_if;
  import irq_level_pkg::*;

  logic [NSRC-1:0][FIELD_W-1:0] field;
  logic [NSRC-1:0]              pending;
  logic [NSRC-1:0]              enabled;
  logic                         fwd_valid;
  logic [LEVEL_W-1:0]           fwd_level;
  logic [SRC_W-1:0]             fwd_source;
  logic [NLEVEL-1:0]            level_active;

  modport arb (
    input  field,
    input  pending,
    output enabled,
    output fwd_valid,
    output fwd_level,
    output fwd_source,
    output level_active
  );

  modport ctrl (
    output field,
    output pending,
    input  enabled,
    input  fwd_valid,
    input  fwd_level,
    input  fwd_source,
    input  level_active
  );
endinterface : irq_fwd_if

//--- verilog/req_sync.sv
// Two-flop synchroniser for request lines from other domains or pins
`timescale 1ns/1ps
module req_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : req_sync

//--- verilog/level_arbiter.sv
// Field decode and highest-level pick among enabled pending sources
`timescale 1ns/1ps
module level_arbiter
  import irq_level_pkg::*;
(
  // Configuration and requests in, forwarded request out
  irq_fwd_if.arb bus
);

  always_comb begin
    logic [LEVEL_W-1:0] lvl;
    lvl              = LEVEL_0;
    bus.enabled      = '0;
    bus.fwd_valid    = 1'b0;
    bus.fwd_level    = LEVEL_0;
    bus.fwd_source   = '0;
    bus.level_active = '0;
    // Walk downward so that the lowest index wins a tie at equal level
    for (int i = NSRC - 1; i >= 0; i--) begin
      lvl = LEVEL_0;
      unique case (bus.field[i])
        FIELD_OFF:  lvl = LEVEL_0;
        FIELD_LVL0: lvl = LEVEL_0; // see RULE_01
        FIELD_LVL1: lvl = LEVEL_1; // see RULE_01
        FIELD_LVL2: lvl = LEVEL_2; // see RULE_01, see RULE_04
      endcase
      bus.enabled[i] = (bus.field[i] != FIELD_OFF); // see RULE_01
      if (bus.enabled[i] && bus.pending[i]) begin // see RULE_13
        bus.level_active[lvl] = 1'b1;
        if (!bus.fwd_valid || lvl >= bus.fwd_level) begin
          bus.fwd_valid  = 1'b1;
          bus.fwd_level  = lvl; // see RULE_13
          bus.fwd_source = SRC_W'(i);
        end
      end
    end
  end

endmodule : level_arbiter

//--- verilog/irq_level_ctrl.sv
// Interrupt priority level configuration registers with APB access
//
// Overview of operation
// RULE_01: field 00 off, 01/10/11 give levels 0/1/2
// RULE_02: all level fields reset to zero, sources off
// RULE_03: reserved bits read zero, ignore writes
// RULE_04: these sources reach levels zero to two only
// RULE_05: cfg_2 bits 11:10 flash, 9:8 pll, 7:6 voltage
// RULE_06: cfg_2 5:4 reserved, 3:2 request B, 1:0 A
// RULE_07: cfg_3 bits 15:10 set ports D, E, F
// RULE_08: cfg_3 bits 9:2 CAN sources, 1:0 reserved
// RULE_09: cfg_4 bits 15:10 set serial port levels
// RULE_10: cfg_4 9:6 reserved, 5:0 ports A, B, C
// RULE_11: cfg_5 15:12 decoder index and home levels
// RULE_12: cfg_5 bits 11:10 set uart receive level
// RULE_13: forward pending request only if enabled, with level
`timescale 1ns/1ps
module irq_level_ctrl
  import irq_level_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [APB_AW-1:0]    paddr,
  input  wire logic [APB_DW-1:0]    pwdata,
  output logic      [APB_DW-1:0]    prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Peripheral request lines, active high levels
  input  wire logic [NSRC-1:0]      src_req,
  // Forwarded request to the core
  output logic                      core_req,
  output logic      [LEVEL_W-1:0]   core_level,
  output logic      [SRC_W-1:0]     core_source,
  output logic      [NLEVEL-1:0]    level_active,
  // Event interrupt
  output logic                      irq
);

  irq_fwd_if fwd ();

  logic [NSRC-1:0]            req_sync_s;
  logic [NSRC-1:0]            req_prev_q;
  logic [NSRC-1:0]            req_prev_d;

  logic [NCFG-1:0][REG_W-1:0] cfg_q;
  logic [NCFG-1:0][REG_W-1:0] cfg_d;
  logic [NSRC-1:0]            status_q;
  logic [NSRC-1:0]            status_d;
  logic [NSRC-1:0]            mask_q;
  logic [NSRC-1:0]            mask_d;

  logic [APB_DW-1:0]          prdata_q;
  logic [APB_DW-1:0]          prdata_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;

  logic                       core_req_q;
  logic                       core_req_d;
  logic [LEVEL_W-1:0]         core_level_q;
  logic [LEVEL_W-1:0]         core_level_d;
  logic [SRC_W-1:0]           core_source_q;
  logic [SRC_W-1:0]           core_source_d;
  logic [NLEVEL-1:0]          level_active_q;
  logic [NLEVEL-1:0]          level_active_d;
  logic                       irq_q;
  logic                       irq_d;

  logic                       setup_phase;
  logic                       access_done;
  logic [IDX_W-1:0]           reg_idx;
  logic                       cfg_hit;
  logic [NSRC-1:0]            event_set;
  logic [NSRC-1:0]            event_clr;

  // External request pins and other-domain sources all pass two flops
  req_sync #(
    .WIDTH (NSRC)
  ) u_req_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       (src_req),
    .q       (req_sync_s)
  );

  // One level field per source; reserved slots carry no field
  logic [FIELD_W-1:0]         flash_error_level;
  logic [FIELD_W-1:0]         pll_unlocked_level;
  logic [FIELD_W-1:0]         low_voltage_level;
  logic [FIELD_W-1:0]         ext_request_b_level;
  logic [FIELD_W-1:0]         ext_request_a_level;
  logic [FIELD_W-1:0]         port_d_level;
  logic [FIELD_W-1:0]         port_e_level;
  logic [FIELD_W-1:0]         port_f_level;
  logic [FIELD_W-1:0]         can_msgbuf_level;
  logic [FIELD_W-1:0]         can_wakeup_level;
  logic [FIELD_W-1:0]         can_error_level;
  logic [FIELD_W-1:0]         can_busoff_level;
  logic [FIELD_W-1:0]         serial0_rx_full_level;
  logic [FIELD_W-1:0]         serial1_tx_empty_level;
  logic [FIELD_W-1:0]         serial1_rx_full_level;
  logic [FIELD_W-1:0]         port_a_level;
  logic [FIELD_W-1:0]         port_b_level;
  logic [FIELD_W-1:0]         port_c_level;
  logic [FIELD_W-1:0]         decoder1_index_level;
  logic [FIELD_W-1:0]         decoder1_home_wdog_level;
  logic [FIELD_W-1:0]         uart1_rx_full_level;

  // cfg_2
  assign flash_error_level        = cfg_q[SRC_CFG[0]][SRC_LSB[0] +: FIELD_W]; // see RULE_05
  assign pll_unlocked_level       = cfg_q[SRC_CFG[1]][SRC_LSB[1] +: FIELD_W]; // see RULE_05
  assign low_voltage_level        = cfg_q[SRC_CFG[2]][SRC_LSB[2] +: FIELD_W]; // see RULE_05
  assign ext_request_b_level      = cfg_q[SRC_CFG[3]][SRC_LSB[3] +: FIELD_W]; // see RULE_06
  assign ext_request_a_level      = cfg_q[SRC_CFG[4]][SRC_LSB[4] +: FIELD_W]; // see RULE_06

  // cfg_3
  assign port_d_level             = cfg_q[SRC_CFG[5]][SRC_LSB[5] +: FIELD_W]; // see RULE_07
  assign port_e_level             = cfg_q[SRC_CFG[6]][SRC_LSB[6] +: FIELD_W]; // see RULE_07
  assign port_f_level             = cfg_q[SRC_CFG[7]][SRC_LSB[7] +: FIELD_W]; // see RULE_07
  assign can_msgbuf_level         = cfg_q[SRC_CFG[8]][SRC_LSB[8] +: FIELD_W]; // see RULE_08
  assign can_wakeup_level         = cfg_q[SRC_CFG[9]][SRC_LSB[9] +: FIELD_W]; // see RULE_08
  assign can_error_level          = cfg_q[SRC_CFG[10]][SRC_LSB[10] +: FIELD_W]; // see RULE_08
  assign can_busoff_level         = cfg_q[SRC_CFG[11]][SRC_LSB[11] +: FIELD_W]; // see RULE_08

  // cfg_4
  assign serial0_rx_full_level    = cfg_q[SRC_CFG[12]][SRC_LSB[12] +: FIELD_W]; // see RULE_09
  assign serial1_tx_empty_level   = cfg_q[SRC_CFG[13]][SRC_LSB[13] +: FIELD_W]; // see RULE_09
  assign serial1_rx_full_level    = cfg_q[SRC_CFG[14]][SRC_LSB[14] +: FIELD_W]; // see RULE_09
  assign port_a_level             = cfg_q[SRC_CFG[15]][SRC_LSB[15] +: FIELD_W]; // see RULE_10
  assign port_b_level             = cfg_q[SRC_CFG[16]][SRC_LSB[16] +: FIELD_W]; // see RULE_10
  assign port_c_level             = cfg_q[SRC_CFG[17]][SRC_LSB[17] +: FIELD_W]; // see RULE_10

  // cfg_5
  assign decoder1_index_level     = cfg_q[SRC_CFG[18]][SRC_LSB[18] +: FIELD_W]; // see RULE_11
  assign decoder1_home_wdog_level = cfg_q[SRC_CFG[19]][SRC_LSB[19] +: FIELD_W]; // see RULE_11
  assign uart1_rx_full_level      = cfg_q[SRC_CFG[20]][SRC_LSB[20] +: FIELD_W]; // see RULE_12

  // Packed in source order, source zero at the right
  assign fwd.field = {
    uart1_rx_full_level,
    decoder1_home_wdog_level,
    decoder1_index_level,
    port_c_level,
    port_b_level,
    port_a_level,
    serial1_rx_full_level,
    serial1_tx_empty_level,
    serial0_rx_full_level,
    can_busoff_level,
    can_error_level,
    can_wakeup_level,
    can_msgbuf_level,
    port_f_level,
    port_e_level,
    port_d_level,
    ext_request_a_level,
    ext_request_b_level,
    low_voltage_level,
    pll_unlocked_level,
    flash_error_level
  };
  assign fwd.pending = req_sync_s;

  level_arbiter u_level_arbiter (
    .bus (fwd.arb)
  );

  // APB decode
  assign setup_phase = psel && !penable;
  // Slave always answers in the first access cycle
  assign access_done = psel && penable && pready_q;
  assign reg_idx     = paddr[IDX_LSB +: IDX_W];

  always_comb begin
    cfg_hit = 1'b0;
    for (int k = 0; k < NCFG; k++) begin
      if (reg_idx == IDX_W'(int'(IDX_CFG_2) + k)) begin
        cfg_hit = 1'b1;
      end
    end
  end

  // Level configuration registers
  always_comb begin
    cfg_d = cfg_q;
    for (int k = 0; k < NCFG; k++) begin
      if (access_done && pwrite && reg_idx == IDX_W'(int'(IDX_CFG_2) + k)) begin
        // Reserved positions are never stored, so they read back as zero
        cfg_d[k] = pwdata[REG_W-1:0] & CFG_WMASK[k]; // see RULE_03, see RULE_07, see RULE_08
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NCFG; k++) begin
        cfg_q[k] <= CFG_RESET; // see RULE_02
      end
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Event status and mask; a rising request of an enabled source is an event
  always_comb begin
    req_prev_d = req_sync_s;
    event_set  = req_sync_s & ~req_prev_q & fwd.enabled;
    event_clr  = '0;
    mask_d     = mask_q;
    if (access_done && pwrite && reg_idx == IDX_STATUS) begin
      event_clr = pwdata[NSRC-1:0];
    end
    if (access_done && pwrite && reg_idx == IDX_MASK) begin
      mask_d = pwdata[NSRC-1:0];
    end
    // A new event in the clearing cycle survives the clear
    status_d = (status_q & ~event_clr) | event_set;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_prev_q <= '0;
      status_q   <= STATUS_RESET;
      mask_q     <= MASK_RESET;
      irq_q      <= 1'b0;
    end else begin
      req_prev_q <= req_prev_d;
      status_q   <= status_d;
      mask_q     <= mask_d;
      irq_q      <= irq_d;
    end
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_comb begin
    prdata_d  = prdata_q;
    pready_d  = setup_phase;
    pslverr_d = 1'b0;
    if (setup_phase) begin
      prdata_d = RDATA_ZERO;
      if (cfg_hit) begin
        for (int k = 0; k < NCFG; k++) begin
          if (reg_idx == IDX_W'(int'(IDX_CFG_2) + k)) begin
            prdata_d[REG_W-1:0] = cfg_q[k] & CFG_WMASK[k]; // see RULE_03, see RULE_09, see RULE_10
          end
        end
      end else if (reg_idx == IDX_STATUS) begin
        prdata_d[NSRC-1:0] = status_q;
      end else if (reg_idx == IDX_MASK) begin
        prdata_d[NSRC-1:0] = mask_q;
      end else begin
        // Unmapped index: zero data and an error answer
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q  <= RDATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Forwarded request, one cycle behind the arbiter
  always_comb begin
    core_req_d     = fwd.fwd_valid; // see RULE_13
    core_level_d   = fwd.fwd_level; // see RULE_04, see RULE_11, see RULE_12
    core_source_d  = fwd.fwd_source;
    level_active_d = fwd.level_active;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_req_q     <= 1'b0;
      core_level_q   <= LEVEL_0;
      core_source_q  <= '0;
      level_active_q <= '0;
    end else begin
      core_req_q     <= core_req_d;
      core_level_q   <= core_level_d;
      core_source_q  <= core_source_d;
      level_active_q <= level_active_d;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign core_req     = core_req_q;
  assign core_level   = core_level_q;
  assign core_source  = core_source_q;
  assign level_active = level_active_q;
  assign irq          = irq_q;

endmodule : irq_level_ctrl

//--- tb/irq_level_props.sv
// Port-level assertions for the priority level block
`timescale 1ns/1ps
module irq_level_props
  import irq_level_pkg::*;
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [APB_AW-1:0]  paddr,
  input wire logic [APB_DW-1:0]  pwdata,
  input wire logic [APB_DW-1:0]  prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Requests and outputs
  input wire logic [NSRC-1:0]    src_req,
  input wire logic               core_req,
  input wire logic [LEVEL_W-1:0] core_level,
  input wire logic [SRC_W-1:0]   core_source,
  input wire logic [NLEVEL-1:0]  level_active,
  input wire logic               irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Readable bits per index; zero marks an unmapped index
  function automatic logic [31:0] rmask(input logic [IDX_W-1:0] i);
    case (i)
      IDX_CFG_2: return 32'h00000FCF;
      IDX_CFG_3: return 32'h0000FFFC;
      IDX_CFG_4: return 32'h0000FC3F;
      IDX_CFG_5: return 32'h0000FC00;
      IDX_STATUS, IDX_MASK: return 32'h001FFFFF;
      default: return 32'h00000000;
    endcase
  endfunction : rmask

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence quiet_s;
    (src_req == '0)[*3];
  endsequence

  AST_PREADY_SETUP: assert property (setup_s |=> pready)
    else $error("no answer one cycle after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RSV_READ: assert property (
    pready && !pwrite |-> (prdata & ~rmask(paddr[7:2])) == '0)
    else $error("reserved bits read nonzero");
  AST_UNMAPPED: assert property (pready |-> pslverr == (rmask(paddr[7:2]) == '0))
    else $error("error response wrong for index");
  AST_NO_LEVEL3: assert property (
    core_req |-> core_level != 2'h3 && level_active[core_level])
    else $error("bad forwarded level");
  AST_IDLE_ZERO: assert property (
    !core_req |-> core_level == '0 && core_source == '0 && level_active == '0)
    else $error("idle outputs not zero");
  AST_QUIET: assert property (quiet_s |=> !core_req)
    else $error("request forwarded with no source");
  AST_RESET_OFF: assert property ($rose(nrst) |-> !core_req && !irq)
    else $error("outputs active after reset");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> core_req || ($past(pready) && $past(pwrite)))
    else $error("irq rose without cause");
endmodule : irq_level_props

bind irq_level_ctrl irq_level_props i_props (.sys_clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .src_req, .core_req, .core_level,
  .core_source, .level_active, .irq);

//--- tb/src_model.sv
// Peripheral request sources facing the block
`timescale 1ns/1ps
module src_model
  import irq_level_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             nrst,
  // Wanted pattern and request lines
  input wire logic [NSRC-1:0]  want,
  output logic     [NSRC-1:0]  src_req
);
  logic [NSRC-1:0] req_q;
  // Requests are levels held until the source drops them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
    end else begin
      req_q <= want;
    end
  end
  assign src_req = req_q;
endmodule : src_model

//--- tb/irq_priority_level_config_test.sv
// Self-checking bench for the priority level block
`timescale 1ns/1ps
module irq_priority_level_config_test;
  import irq_level_pkg::*;
  localparam logic [15:0] WM [4] = '{16'h0FCF, 16'hFFFC, 16'hFC3F, 16'hFC00};
  localparam int LSB [NSRC] = '{10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0,
    14, 12, 10};
  localparam logic [5:0] IX [6] = '{IDX_CFG_2, IDX_CFG_3, IDX_CFG_4, IDX_CFG_5, IDX_STATUS,
    IDX_MASK};
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic pready, pslverr, core_req, irq, er;
  logic [1:0] core_level, e_lvl;
  logic [4:0] core_source, e_src;
  logic [2:0] level_active, e_act;
  logic [20:0] want = 0, src_req;
  logic [15:0] cfg_m [4];
  int err_total = 0, samples_checked = 0, cyc = 0;

  always #2 sys_clk = ~sys_clk;

  irq_level_ctrl i_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_req, .core_req, .core_level, .core_source, .level_active, .irq);
  src_model i_src (.sys_clk, .nrst, .want, .src_req);

  task tally_and_finish;
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs about 1300 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One idle cycle after each transfer keeps drivers single per time step
  task apb(input logic w, input logic [5:0] ix, input logic [31:0] dv);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= dv;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb

  function void expect_out(input logic [20:0] r);
    int f;
    {e_lvl, e_src, e_act} = '0;
    for (int k = 0; k < NSRC; k++) begin
      f = cfg_m[k < 5 ? 0 : k < 12 ? 1 : k < 18 ? 2 : 3][LSB[k] +: 2];
      if (r[k] && f != 0) begin
        if (e_act == 0 || f - 1 > e_lvl) begin
          e_lvl = 2'(f - 1);
          e_src = 5'(k);
        end
        e_act[f - 1] = 1;
      end
    end
  endfunction : expect_out

  initial begin
    void'($urandom(86902));
    repeat (12) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    for (int j = 0; j < 6; j++) begin
      apb(0, IX[j], 0);
      chk(rd, 0);
    end
    apb(1, 6'h01, '1);
    chk(rd, 0);
    chk(32'(er), 1);
    apb(0, 6'h06, 0);
    chk(rd, 0);
    chk(32'(er), 1);
    $display("test reset and unmapped done");
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 4; j++) begin
        d = i == 0 ? 0 : i == 1 ? '1 : $urandom;
        cfg_m[j] = d[15:0] & WM[j];
        apb(1, IX[j], d);
        apb(0, IX[j], 0);
        chk(rd, 32'(cfg_m[j]));
      end
      want <= i < 2 ? '1 : 21'($urandom & $urandom);
      repeat (6) @(posedge sys_clk);
      expect_out(want);
      rd = 32'({core_req, core_level, core_source, level_active});
      d = 32'({e_act != 0, e_lvl, e_src, e_act});
      chk(rd, d);
    end
    $display("test random levels done");
    want <= 0;
    apb(1, IDX_CFG_2, 32'h1);
    cfg_m[0] = 16'h1;
    apb(1, IDX_STATUS, '1);
    apb(1, IDX_MASK, 0);
    want <= 21'h10;
    repeat (6) @(posedge sys_clk);
    rd = 32'({core_req, core_level, core_source, irq});
    chk(rd, 32'({1'h1, 2'h0, 5'h04, 1'h0}));
    apb(0, IDX_STATUS, 0);
    chk(rd, 32'h10);
    apb(1, IDX_MASK, 32'h10);
    chk(32'(irq), 1);
    apb(1, IDX_STATUS, 32'h10);
    chk(32'(irq), 0);
    apb(0, IDX_STATUS, 0);
    chk(rd, 0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : irq_priority_level_config_test
